// >>> core/fsid_core.sv
`timescale 1ns/1ps
`default_nettype none
module fsid_core
	import fsid_pkg::*;
#(
	parameter int ERASE_CYC = fsid_pkg::SECREG_ERASE_CYC,
	parameter logic [63:0] UID_DEFAULT = 64'h0123456789ABCDEF
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// serial link pins
	input wire logic spi_cs_n,
	input wire logic spi_sclk,
	input wire logic [3:0] spi_io_in,
	output logic [3:0] spi_io_out,
	output logic [3:0] spi_io_oe,
	// identity and table contents
	input wire fsid_pkg::fsid_ids_t ids,
	input wire logic [63:0] unique_id,
	input wire fsid_pkg::fsid_tbl_wr_t tbl_wr,
	// status and control bits
	input wire logic pd_enter,
	input wire logic wen_set,
	input wire logic ext_busy,
	input wire logic [2:0] otp_lock_bits,
	output logic busy,
	output logic write_enable_latch,
	output logic power_down,
	// security register erase
	output logic [1:0] secreg_sel,
	output logic secreg_erasing,
	output logic secreg_erase_done
);
	import fsid_pkg::*;

	// ----------------------------------------
	// pin synchronisers and edges
	// ----------------------------------------
	logic [5:0] pins_s;
	logic cs_s, sck_s;
	logic [3:0] io_s;
	// select resets to its idle high level, so no false edge after reset
	fsid_sync #(.W(6), .RST_VAL(6'h20)) u_sync (
		.sys_clk(sys_clk),
		.rstn(rstn),
		.async_in({spi_cs_n, spi_sclk, spi_io_in}),
		.sync_out(pins_s)
	);
	assign cs_s = pins_s[5];
	assign sck_s = pins_s[4];
	assign io_s = pins_s[3:0];

	logic sck_d_r, cs_d_r;
	wire sck_rise = sck_s & ~sck_d_r & ~cs_s;
	wire sck_fall = ~sck_s & sck_d_r & ~cs_s;
	wire cs_rise = cs_s & ~cs_d_r;

	// ----------------------------------------
	// frame state
	// ----------------------------------------
	fsid_phase_t ph_r, ph_nxt;
	logic [7:0] cnt_r, op_r, byte_idx_r, osr_r;
	logic [23:0] addr_r;
	logic [2:0] obit_r;
	logic [3:0] io_out_r, io_oe_r;
	logic pd_r, waking_r, busy_r, wen_r, done_r;
	logic [8:0] wake_cnt_r;
	logic [31:0] ers_cnt_r;
	logic [1:0] sel_r;
	logic [7:0] tbl_r [TBL_DEPTH];

	wire [7:0] op_nx = {op_r[6:0], io_s[0]};
	wire busy_all = busy_r | ext_busy;
	wire known = (op_nx == OP_WAKE) | (op_nx == OP_MID1) |
		(op_nx == OP_MID2) | (op_nx == OP_MID4) | (op_nx == OP_UID) |
		(op_nx == OP_STDID) | (op_nx == OP_TBL) | (op_nx == OP_SRERASE);
	// busy first: an id request must not disturb a running cycle
	wire op_skip = busy_all | waking_r | ~known |
		(pd_r & (op_nx != OP_WAKE)) |
		((op_nx == OP_SRERASE) & ~wen_r);
	wire op_done = sck_rise & (ph_r == PH_CMD) & (cnt_r == CNT_OP - 8'h01);

	// ----------------------------------------
	// address capture windows and lanes
	// ----------------------------------------
	wire is_dual = (op_r == OP_MID2);
	wire is_quad = (op_r == OP_MID4);
	wire in_win1 = ((op_r == OP_MID1) | (op_r == OP_TBL) |
		(op_r == OP_SRERASE)) & (cnt_r < CNT_ADDR_END);
	wire in_win2 = is_dual & (cnt_r < CNT_DUAL_ADDR_END);
	wire in_win4 = is_quad & (cnt_r >= CNT_QUAD_ADDR_BEG) &
		(cnt_r < CNT_QUAD_ADDR_END);
	wire addr_take = sck_rise & (ph_r == PH_IN);
	wire [2:0] out_lanes = is_quad ? 3'h4 : (is_dual ? 3'h2 : 3'h1);

	// ----------------------------------------
	// output start point per opcode
	// ----------------------------------------
	wire [7:0] out_at =
		(op_r == OP_WAKE) ? OUT_AT_WAKE :
		(op_r == OP_MID1) ? OUT_AT_MID1 :
		(op_r == OP_MID2) ? OUT_AT_MID2 :
		(op_r == OP_MID4) ? OUT_AT_MID4 :
		(op_r == OP_UID) ? OUT_AT_UID :
		(op_r == OP_STDID) ? OUT_AT_STDID :
		(op_r == OP_TBL) ? OUT_AT_TBL : 8'hFF;
	wire tbl_addr_ok = (op_r != OP_TBL) | (addr_r[23:8] == 16'h0000);
	wire out_go = sck_fall & (ph_r == PH_IN) & ~pd_r &
		(op_r != OP_SRERASE) & tbl_addr_ok &
		(cnt_r >= out_at);
	wire out_step = sck_fall & ((ph_r == PH_OUT) | out_go);

	// ----------------------------------------
	// next output byte
	// ----------------------------------------
	wire [7:0] idx_eff = (ph_r == PH_OUT) ? byte_idx_r :
		((op_r == OP_TBL) ? addr_r[7:0] : 8'h00);
	wire [5:0] uid_sh = {~idx_eff[2:0], 3'b000};
	wire [7:0] uid_byte = unique_id[uid_sh +: 8];
	wire [7:0] std_byte = (idx_eff == 8'h00) ? ids.mfr :
		(idx_eff == 8'h01) ? ids.memory_type_byte :
		(idx_eff == 8'h02) ? ids.capacity_byte : 8'h00;
	wire [7:0] pair_byte = idx_eff[0] ? ids.dev : ids.mfr;
	wire [7:0] nb =
		(op_r == OP_WAKE) ? ids.dev :
		(op_r == OP_UID) ? uid_byte :
		(op_r == OP_STDID) ? std_byte :
		(op_r == OP_TBL) ? tbl_r[idx_eff] : pair_byte;
	wire [7:0] odata = (obit_r == 3'h0) ? nb : osr_r;
	wire [7:0] osr_nx = (out_lanes == 3'h4) ? {odata[3:0], 4'h0} :
		(out_lanes == 3'h2) ? {odata[5:0], 2'b00} : {odata[6:0], 1'b0};
	wire [3:0] lanes_nx = (out_lanes == 3'h4) ? odata[7:4] :
		(out_lanes == 3'h2) ? {2'b00, odata[7:6]} : {2'b00, odata[7], 1'b0};
	wire [3:0] oe_nx = (out_lanes == 3'h4) ? 4'hF :
		(out_lanes == 3'h2) ? 4'h3 : 4'h2;

	// ----------------------------------------
	// security register erase decode
	// ----------------------------------------
	wire [1:0] sr_sel = addr_r[13:12];
	wire sr_addr_ok = (addr_r[23:16] == 8'h00) & (addr_r[15:14] == 2'b00) &
		(sr_sel != 2'b00) & (addr_r[11:8] == 4'h0);
	wire lock_hit = ((sr_sel == 2'b01) & otp_lock_bits[0]) |
		((sr_sel == 2'b10) & otp_lock_bits[1]) |
		((sr_sel == 2'b11) & otp_lock_bits[2]);
	// select must rise right after the last address bit, no extra clocks
	wire ers_start = cs_rise & (ph_r == PH_IN) & (op_r == OP_SRERASE) &
		(cnt_r == CNT_ADDR_END) & sr_addr_ok & ~lock_hit & wen_r &
		~busy_all;
	wire ers_end = busy_r & (ers_cnt_r == 32'd0);
	wire wake_start = cs_rise & (ph_r == PH_IN) & (op_r == OP_WAKE) &
		(cnt_r == CNT_OP) & pd_r;
	wire wake_end = waking_r & (wake_cnt_r == 9'd0);

	// ----------------------------------------
	// phase machine
	// ----------------------------------------
	always_comb begin
		ph_nxt = ph_r;
		case (ph_r)
			PH_CMD: begin
				if (op_done)
					ph_nxt = op_skip ? PH_SKIP : PH_IN;
			end
			PH_IN: begin
				if (out_go)
					ph_nxt = PH_OUT;
			end
			PH_OUT: ph_nxt = PH_OUT;
			PH_SKIP: ph_nxt = PH_SKIP;
			default: ph_nxt = PH_SKIP;
		endcase
		if (cs_s)
			ph_nxt = PH_CMD;
	end

	// ----------------------------------------
	// link-facing registers
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			sck_d_r <= 1'b0;
			cs_d_r <= 1'b1;
			ph_r <= PH_CMD;
			cnt_r <= 8'h00;
			op_r <= 8'h00;
		end else begin
			sck_d_r <= sck_s;
			cs_d_r <= cs_s;
			ph_r <= ph_nxt;
			if (cs_s)
				cnt_r <= 8'h00;
			else if (sck_rise && cnt_r != 8'hFF)
				cnt_r <= cnt_r + 8'h01;
			if (sck_rise && ph_r == PH_CMD)
				op_r <= op_nx;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn)
			addr_r <= 24'h000000;
		else if (addr_take && in_win1)
			addr_r <= {addr_r[22:0], io_s[0]};
		else if (addr_take && in_win2)
			addr_r <= {addr_r[21:0], io_s[1:0]};
		else if (addr_take && in_win4)
			addr_r <= {addr_r[19:0], io_s[3:0]};
	end

	// ----------------------------------------
	// output shifter, changes on falling clock
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!rstn || cs_s) begin
			obit_r <= 3'h0;
			osr_r <= 8'h00;
			byte_idx_r <= 8'h00;
			io_out_r <= 4'h0;
			io_oe_r <= 4'h0;
		end else if (out_step) begin
			// lane counts 1, 2 and 4 all wrap the 3-bit count at 8
			obit_r <= obit_r + out_lanes;
			osr_r <= osr_nx;
			io_out_r <= lanes_nx;
			io_oe_r <= oe_nx;
			if (obit_r == 3'h0)
				byte_idx_r <= idx_eff + 8'h01;
		end
	end
	assign spi_io_out = io_out_r;
	assign spi_io_oe = io_oe_r;

	// parameter table, loaded by on-chip logic
	always_ff @(posedge sys_clk) begin
		if (tbl_wr.we)
			tbl_r[tbl_wr.addr] <= tbl_wr.data;
	end

	// ----------------------------------------
	// power-down, wake, erase and latch
	// ----------------------------------------
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			pd_r <= 1'b0;
			waking_r <= 1'b0;
			wake_cnt_r <= 9'd0;
		end else if (wake_start) begin
			waking_r <= 1'b1;
			wake_cnt_r <= 9'(WAKE_CYC - 1);
		end else if (wake_end) begin
			waking_r <= 1'b0;
			pd_r <= 1'b0;
		end else begin
			if (waking_r)
				wake_cnt_r <= wake_cnt_r - 9'd1;
			if (pd_enter && !busy_all && !waking_r)
				pd_r <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			busy_r <= 1'b0;
			ers_cnt_r <= 32'd0;
			sel_r <= 2'b00;
			done_r <= 1'b0;
		end else begin
			done_r <= ers_end;
			if (ers_start) begin
				busy_r <= 1'b1;
				ers_cnt_r <= 32'(ERASE_CYC - 1);
				sel_r <= sr_sel;
			end else if (ers_end) begin
				busy_r <= 1'b0;
			end else if (busy_r) begin
				ers_cnt_r <= ers_cnt_r - 32'd1;
			end
		end
	end

	// set wins over the end-of-erase clear
	always_ff @(posedge sys_clk) begin
		if (!rstn)
			wen_r <= 1'b0;
		else if (wen_set)
			wen_r <= 1'b1;
		else if (ers_end)
			wen_r <= 1'b0;
	end

	assign busy = busy_all;
	assign write_enable_latch = wen_r;
	assign power_down = pd_r;
	assign secreg_sel = sel_r;
	assign secreg_erasing = busy_r;
	assign secreg_erase_done = done_r;

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rstn);

	chk_wake_delay: assert property (
		$fell(pd_r) |-> $past(waking_r) && $past(wake_cnt_r) == 9'd0)
		else $error("left power-down before wake delay");
	chk_pd_no_output: assert property (
		pd_r |-> ph_r != PH_OUT)
		else $error("output driven in power-down");
	chk_busy_ignore: assert property (
		(op_done && busy_all) |=> ph_r == PH_SKIP || cs_s)
		else $error("command taken while busy");
	chk_erase_wel: assert property (
		$rose(busy_r) |-> $past(wen_r) && $past(cnt_r) == CNT_ADDR_END)
		else $error("erase began without latch or off boundary");
	chk_erase_lock: assert property (
		$rose(busy_r) |-> !$past(lock_hit) && $past(sr_addr_ok))
		else $error("locked or bad register erased");
	chk_erase_end: assert property (
		ers_end |=> !busy_r && (!wen_r || $past(wen_set)) ##1 !done_r)
		else $error("erase end mishandled");
	chk_quad_lanes: assert property (
		(ph_r == PH_OUT && is_quad) |-> spi_io_oe == 4'hF)
		else $error("quad read not on four lanes");
	chk_dev_repeat: assert property (
		(out_step && op_r == OP_WAKE && obit_r == 3'h0 && !cs_s)
		|=> spi_io_out[1] == $past(ids.dev[7]))
		else $error("device id not repeated");
	chk_tbl_start: assert property (
		(out_go && op_r == OP_TBL) |-> cnt_r == OUT_AT_TBL
		##1 spi_io_oe == 4'h2)
		else $error("table output began early");

	cov_erase: cover property ($fell(busy_r));
	cov_wake: cover property ($fell(pd_r));
	cov_quad: cover property (ph_r == PH_OUT && is_quad);
	cov_tbl: cover property (out_go && op_r == OP_TBL);
endmodule // fsid_core
`default_nettype wire

// >>> core/fsid_pkg.sv
// Summary of operation
// - lone wake opcode leaves power-down after delay
// - wake opcode plus three dummies outputs device id outside power-down
// - device id repeats until select rises
// - wake/id opcode ignored while busy
// - single-lane read gives manufacturer then device byte
// - dual-lane read: address and ids two bits/clock
// - quad read: four dummies, address, ids four bits
// - dual/quad ids alternate until select rises
// - unique id opcode, four dummies, 64-bit id out
// - standard id: manufacturer, memory type, capacity
// - table bytes start on fortieth falling clock
// - table address high zero, low byte starts
// - three erasable registers, erase needs enable latch
// - erase decodes register 1..3 from address
// - erase runs only if select rises on boundary
// - erase self-timed with busy, clears busy after
// - locked register never erased
// - in power-down only wake opcode recognised
package fsid_pkg;
	// ----------------------------------------
	// opcodes
	// ----------------------------------------
	localparam logic [7:0] OP_WAKE = 8'hAB;
	localparam logic [7:0] OP_MID1 = 8'h90;
	localparam logic [7:0] OP_MID2 = 8'h92;
	localparam logic [7:0] OP_MID4 = 8'h94;
	localparam logic [7:0] OP_UID = 8'h4B;
	localparam logic [7:0] OP_STDID = 8'h9F;
	localparam logic [7:0] OP_TBL = 8'h5A;
	localparam logic [7:0] OP_SRERASE = 8'h44;
	// ----------------------------------------
	// clock counts within a frame
	// ----------------------------------------
	localparam logic [7:0] CNT_OP = 8'h08;
	localparam logic [7:0] CNT_ADDR_END = 8'h20;
	localparam logic [7:0] CNT_DUAL_ADDR_END = 8'h14;
	localparam logic [7:0] CNT_QUAD_ADDR_BEG = 8'h0C;
	localparam logic [7:0] CNT_QUAD_ADDR_END = 8'h12;
	localparam logic [7:0] OUT_AT_WAKE = 8'h20;
	localparam logic [7:0] OUT_AT_MID1 = 8'h20;
	localparam logic [7:0] OUT_AT_MID2 = 8'h18;
	localparam logic [7:0] OUT_AT_MID4 = 8'h14;
	localparam logic [7:0] OUT_AT_UID = 8'h28;
	localparam logic [7:0] OUT_AT_STDID = 8'h08;
	localparam logic [7:0] OUT_AT_TBL = 8'h28;
	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 8;
	localparam int WAKE_DELAY_NS = 3000;
	localparam int WAKE_CYC = (WAKE_DELAY_NS + CLK_PERIOD_NS - 1) /
		CLK_PERIOD_NS;
	localparam int SECREG_ERASE_TIME_NS = 100000;
	localparam int SECREG_ERASE_CYC = (SECREG_ERASE_TIME_NS +
		CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int TBL_DEPTH = 256;
	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef struct packed {
		logic [7:0] mfr;
		logic [7:0] dev;
		logic [7:0] memory_type_byte;
		logic [7:0] capacity_byte;
	} fsid_ids_t;
	typedef struct packed {
		logic we;
		logic [7:0] addr;
		logic [7:0] data;
	} fsid_tbl_wr_t;
	typedef enum logic [1:0] {
		PH_CMD = 2'b00,
		PH_IN = 2'b01,
		PH_OUT = 2'b11,
		PH_SKIP = 2'b10
	} fsid_phase_t;
endpackage

// >>> core/fsid_sync.sv
`timescale 1ns/1ps
`default_nettype none
module fsid_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rstn,
	// async in, synced out
	input wire logic [W-1:0] async_in,
	output logic [W-1:0] sync_out
);
	logic [W-1:0] meta_r;
	always_ff @(posedge sys_clk) begin
		if (!rstn) begin
			meta_r <= RST_VAL;
			sync_out <= RST_VAL;
		end else begin
			meta_r <= async_in;
			sync_out <= meta_r;
		end
	end
endmodule // fsid_sync
`default_nettype wire

// >>> tb/flash_id_sfdp_secreg_erase_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module flash_id_sfdp_secreg_erase_tb_top;
	import fsid_pkg::*;
	localparam int ECYC = 20;
	logic sys_clk, rstn, spi_cs_n, spi_sclk;
	logic [3:0] spi_io_in, spi_io_out, spi_io_oe;
	fsid_ids_t ids;
	fsid_tbl_wr_t tbl_wr;
	logic [63:0] unique_id, got;
	logic pd_enter, wen_set, ext_busy, busy, write_enable_latch, power_down;
	logic [2:0] otp_lock_bits;
	logic [1:0] secreg_sel;
	logic secreg_erasing, secreg_erase_done;
	logic [7:0] tbl [256];
	logic [7:0] a;
	int fails = 0;
	int check_count = 0;
	int cyc = 0;
	int i;
	integer seed;
	fsid_core #(.ERASE_CYC(ECYC)) dut_u (.sys_clk(sys_clk), .rstn(rstn),
		.spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .spi_io_in(spi_io_in),
		.spi_io_out(spi_io_out), .spi_io_oe(spi_io_oe), .ids(ids),
		.unique_id(unique_id), .tbl_wr(tbl_wr), .pd_enter(pd_enter),
		.wen_set(wen_set), .ext_busy(ext_busy),
		.otp_lock_bits(otp_lock_bits), .busy(busy),
		.write_enable_latch(write_enable_latch), .power_down(power_down),
		.secreg_sel(secreg_sel), .secreg_erasing(secreg_erasing),
		.secreg_erase_done(secreg_erase_done));
	fsid_host host_u (.spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk),
		.spi_io_in(spi_io_in), .spi_io_out(spi_io_out),
		.spi_io_oe(spi_io_oe));
	// ----------------------------------------
	// clock, timeout, helpers
	// ----------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #4 sys_clk = ~sys_clk;
	end
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 60000) begin
			fails++;
			close_out();
		end
	end
	task close_out();
		$display("checks %0d fails %0d", check_count, fails);
		if (fails == 0 && check_count > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	task chk(input logic [63:0] g, input logic [63:0] e, input string m);
		check_count++;
		if (g !== e) begin
			fails++;
			$display("[FAIL] %0t %s got %h exp %h", $time, m, g, e);
		end
	endtask
	function automatic logic [63:0] alt_ids(input fsid_ids_t d);
		return {32'h0, d.mfr, d.dev, d.mfr, d.dev};
	endfunction
	function automatic logic [63:0] std_ids(input fsid_ids_t d);
		return {32'h0, d.mfr, d.memory_type_byte, d.capacity_byte, 8'h00};
	endfunction
	task sr_erase(input logic [1:0] r, input logic [3:0] mid, input int nin,
		input logic wen, input logic exp);
		int n;
		@(posedge sys_clk);
		wen_set <= wen;
		@(posedge sys_clk);
		wen_set <= 1'b0;
		host_u.frame(OP_SRERASE, {48'h0, 2'b00, r, mid, 8'h5C}, nin, 1, 0, 1,
			got);
		repeat (10) @(negedge sys_clk);
		chk(64'(busy), 64'(exp), "erase start");
		if (exp) begin
			chk(64'({secreg_sel, secreg_erasing}), 64'({r, 1'b1}), "sel");
			for (n = 0; n < 1000 && busy === 1'b1; n++) @(negedge sys_clk);
			chk(64'(n > ECYC - 11 && n < ECYC - 3), 64'h1, "erase time");
			chk(64'(write_enable_latch), 64'h0, "latch clear");
			// done rises on the same edge that busy falls, for one cycle
			chk(64'(secreg_erase_done), 64'h1, "done pulse");
			@(negedge sys_clk);
			chk(64'(secreg_erase_done), 64'h0, "done end");
		end else begin
			chk(64'(write_enable_latch), 64'(wen), "latch kept");
		end
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		seed = 32'hd26ad314;
		rstn = 1'b0;
		ids = '0;
		unique_id = '0;
		tbl_wr = '0;
		pd_enter = 1'b0;
		wen_set = 1'b0;
		ext_busy = 1'b0;
		otp_lock_bits = 3'b000;
		repeat (8) @(posedge sys_clk);
		rstn <= 1'b1;
		ids <= fsid_ids_t'($random(seed));
		unique_id <= {$random(seed), $random(seed)};
		// table loaded through the write port, model kept alongside
		for (i = 0; i < 256; i++) begin
			@(posedge sys_clk);
			tbl[i] = 8'($random(seed));
			tbl_wr <= '{1'b1, 8'(i), tbl[i]};
		end
		@(posedge sys_clk);
		tbl_wr <= '0;
		host_u.frame(OP_STDID, 64'h0, 0, 1, 32, 1, got);
		chk(got, std_ids(ids), "std");
		host_u.frame(OP_WAKE, 64'h0, 24, 1, 16, 1, got);
		chk(got, 64'({ids.dev, ids.dev}), "dev id");
		host_u.frame(OP_MID1, 64'h0, 24, 1, 16, 1, got);
		chk(got, 64'({ids.mfr, ids.dev}), "mid1");
		host_u.frame(OP_MID2, 64'h0F3, 16, 2, 16, 2, got);
		chk(got, alt_ids(ids), "mid2");
		host_u.frame(OP_MID4, 64'h0FA, 12, 4, 8, 4, got);
		chk(got, alt_ids(ids), "mid4");
		host_u.frame(OP_UID, 64'h0, 32, 1, 64, 1, got);
		chk(got, unique_id, "uid");
		$display("id reads done");
		for (i = 0; i < 3; i++) begin
			a = (i == 0) ? 8'hFE : 8'($random(seed));
			host_u.frame(OP_TBL, {32'h0, 16'h0, a, 8'h00}, 32, 1, 24, 1, got);
			chk(got, 64'({tbl[a], tbl[8'(a + 1)], tbl[8'(a + 2)]}), "tbl");
		end
		// address 0100FEh: a nonzero high byte must block the output
		host_u.frame(OP_TBL, 64'h000000000100FE00, 32, 1, 8, 1, got);
		chk(64'(host_u.saw_oe), 64'h0, "tbl high addr");
		$display("table reads done");
		for (i = 1; i < 4; i++) begin
			sr_erase(2'(i), 4'h0, 24, 1'b1, 1'b1);
		end
		sr_erase(2'd1, 4'h0, 24, 1'b0, 1'b0);
		sr_erase(2'd0, 4'h0, 24, 1'b1, 1'b0);
		sr_erase(2'd2, 4'h1, 24, 1'b1, 1'b0);
		sr_erase(2'd3, 4'h0, 23, 1'b1, 1'b0);
		@(posedge sys_clk);
		otp_lock_bits <= 3'b010;
		sr_erase(2'd2, 4'h0, 24, 1'b1, 1'b0);
		sr_erase(2'd1, 4'h0, 24, 1'b1, 1'b1);
		$display("erase done");
		@(posedge sys_clk);
		ext_busy <= 1'b1;
		host_u.frame(OP_WAKE, 64'h0, 24, 1, 16, 1, got);
		chk(64'(host_u.saw_oe), 64'h0, "busy ignore");
		@(posedge sys_clk);
		ext_busy <= 1'b0;
		@(posedge sys_clk);
		pd_enter <= 1'b1;
		@(posedge sys_clk);
		pd_enter <= 1'b0;
		repeat (4) @(negedge sys_clk);
		chk(64'(power_down), 64'h1, "pd entry");
		host_u.frame(OP_STDID, 64'h0, 0, 1, 32, 1, got);
		chk(64'(host_u.saw_oe), 64'h0, "pd ignore");
		host_u.frame(OP_WAKE, 64'h0, 0, 1, 0, 1, got);
		// select stays high through the whole wake delay
		repeat (300) @(negedge sys_clk);
		chk(64'(power_down), 64'h1, "wake early");
		repeat (100) @(negedge sys_clk);
		chk(64'(power_down), 64'h0, "wake late");
		host_u.frame(OP_MID1, 64'h0, 24, 1, 16, 1, got);
		chk(got, 64'({ids.mfr, ids.dev}), "after wake");
		$display("power-down done");
		close_out();
	end
endmodule // flash_id_sfdp_secreg_erase_tb_top
`default_nettype wire

// >>> tb/fsid_host.sv
`timescale 1ns/1ps
`default_nettype none
module fsid_host (
	// link pins toward the device
	output logic spi_cs_n,
	output logic spi_sclk,
	output logic [3:0] spi_io_in,
	// device lanes
	input wire logic [3:0] spi_io_out,
	input wire logic [3:0] spi_io_oe
);
	logic [3:0] drv_val;
	logic [3:0] drv_en;
	logic saw_oe;
	// released lanes show the inverse, never a stale copy
	assign spi_io_in = (spi_io_oe & spi_io_out) |
		(~spi_io_oe & (drv_val ~^ drv_en));
	initial begin
		spi_cs_n = 1'b1;
		spi_sclk = 1'b0;
		drv_val = 4'h0;
		drv_en = 4'h0;
		saw_oe = 1'b0;
	end
	always @(spi_io_oe) begin
		if (|spi_io_oe) begin
			saw_oe = 1'b1;
		end
	end
	// ----------------------------------------
	// one framed command, clock idle low
	// ----------------------------------------
	task frame(input logic [7:0] op, input logic [63:0] v, input int nin,
		input int lanes, input int nout, input int olanes,
		output logic [63:0] got);
		int i;
		int k;
		got = '0;
		#200;
		saw_oe = 1'b0;
		spi_cs_n = 1'b0;
		drv_en = 4'h1;
		for (i = 7; i >= 0; i--) begin
			drv_val = {3'b000, op[i]};
			#62.5 spi_sclk = 1'b1;
			#62.5 spi_sclk = 1'b0;
		end
		drv_en = (lanes == 4) ? 4'hF : (lanes == 2) ? 4'h3 : 4'h1;
		for (i = nin - 1; i >= 0; i--) begin
			for (k = 0; k < lanes; k++) begin
				drv_val[k] = v[i * lanes + k];
			end
			#62.5 spi_sclk = 1'b1;
			#62.5 spi_sclk = 1'b0;
		end
		drv_en = 4'h0;
		for (i = 0; i < nout; i++) begin
			#62.5 spi_sclk = 1'b1;
			case (olanes)
				4: got = {got[59:0], spi_io_in};
				2: got = {got[61:0], spi_io_in[1:0]};
				default: got = {got[62:0], spi_io_in[1]};
			endcase
			#62.5 spi_sclk = 1'b0;
		end
		#30;
		spi_cs_n = 1'b1;
	endtask
endmodule // fsid_host
`default_nettype wire
